/* File: isvm_core.sv */
// Design decisions made here: the register offsets and strobed register access.
module isvm_core
  import isvm_pkg::*;
(
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  // peripheral requests (levels)
  input wire logic [7:0] ext_irq_i,
  input wire logic timer0_lo_i,
  input wire logic timer0_hi_i,
  input wire logic timer1_lo_i,
  input wire logic timer1_hi_i,
  input wire logic serial_rx_i,
  input wire logic serial_tx_i,
  input wire logic adc_i,
  input wire logic timebase_i,
  input wire logic watch_i,
  input wire logic flash_i,
  // cpu side
  input wire logic cpu_ack_i,
  output logic irq_req_o,
  output logic [isvm_pkg::ISVM_LINE_W-1:0] irq_line_o,
  output logic [1:0] irq_level_o,
  output logic [15:0] vec_upper_o,
  output logic [15:0] vec_lower_o,
  output logic [isvm_pkg::ISVM_LINES-1:0] pend_o,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // interrupt output
  output logic int_o
);
  import isvm_pkg::*;

  // ---------------------------------------------------------------
  // source to line mapping
  // ---------------------------------------------------------------
  logic [ISVM_LINES-1:0] req;
  always_comb begin
    req = '0;
    req[ISVM_L_EXT4] = ext_irq_i[4];
    req[ISVM_L_EXT5] = ext_irq_i[5];
    req[ISVM_L_EXT26] = ext_irq_i[2] | ext_irq_i[6];
    req[ISVM_L_EXT37] = ext_irq_i[3] | ext_irq_i[7];
    req[ISVM_L_T0LO] = timer0_lo_i;
    req[ISVM_L_T0HI] = timer0_hi_i;
    req[ISVM_L_T1HI] = timer1_hi_i;
    req[ISVM_L_T1LO] = timer1_lo_i;
    req[ISVM_L_SRX] = serial_rx_i;
    req[ISVM_L_STX] = serial_tx_i;
    req[ISVM_L_ADC] = adc_i;
    req[ISVM_L_TBT] = timebase_i;
    req[ISVM_L_WPS] = watch_i;
    req[ISVM_L_FLASH] = flash_i;
  end

  // ---------------------------------------------------------------
  // level-setting registers
  // ---------------------------------------------------------------
  logic [7:0] lvl_ff [ISVM_LVL_REGS];
  logic [7:0] lvl_idx;
  logic lvl_hit;
  assign lvl_idx = reg_addr_i - ISVM_LVL_BASE;
  assign lvl_hit = (reg_addr_i >= ISVM_LVL_BASE) &&
                   (lvl_idx < 8'(ISVM_LVL_REGS));

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < ISVM_LVL_REGS; i++) begin
        lvl_ff[i] <= ISVM_LVL_RESET;
      end
    end else if (clk_en_i && reg_wr_i && lvl_hit) begin
      lvl_ff[lvl_idx[2:0]] <= reg_wdata_i;
    end
  end

  function automatic logic [1:0] line_level(input int unsigned n);
    logic [7:0] r;
    r = lvl_ff[n / 4];
    line_level = r[(n % 4) * 2 +: 2];
  endfunction

  // ---------------------------------------------------------------
  // arbitration
  // ---------------------------------------------------------------
  logic win_found;
  logic win_tie;
  logic [ISVM_LINE_W-1:0] win_line;
  logic [1:0] win_lvl;
  always_comb begin
    win_found = 1'b0;
    win_tie = 1'b0;
    win_line = '0;
    win_lvl = ISVM_LVL_LOWEST;
    // strict less-than keeps the lower line on equal level
    for (int n = 0; n < ISVM_LINES; n++) begin
      if (req[n]) begin
        if (!win_found || line_level(n) < win_lvl) begin
          win_found = 1'b1;
          win_line = ISVM_LINE_W'(n);
          win_lvl = line_level(n);
        end else if (line_level(n) == win_lvl) begin
          win_tie = 1'b1;
        end
      end
    end
  end

  isvm_state_t state_ff;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_ff <= ISVM_IDLE;
      irq_req_o <= 1'b0;
      irq_line_o <= '0;
      irq_level_o <= ISVM_LVL_LOWEST;
      vec_upper_o <= ISVM_VEC_TOP;
      vec_lower_o <= ISVM_VEC_TOP + 16'h0001;
      pend_o <= '0;
    end else if (clk_en_i) begin
      pend_o <= req;
      case (state_ff)
        ISVM_IDLE: begin
          irq_req_o <= win_found;
          irq_line_o <= win_line;
          irq_level_o <= win_lvl;
          vec_upper_o <= isvm_vec_upper(win_line);
          vec_lower_o <= isvm_vec_upper(win_line) + 16'h0001;
          if (win_found) begin
            state_ff <= ISVM_WAIT_ACK;
          end
        end
        ISVM_WAIT_ACK: begin
          // hold the offered vector stable until the cpu takes it
          if (cpu_ack_i) begin
            irq_req_o <= 1'b0;
            state_ff <= ISVM_IDLE;
          end
        end
        default: state_ff <= ISVM_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // event status, mask, interrupt
  // ---------------------------------------------------------------
  logic [7:0] status_ff;
  logic [7:0] mask_ff;
  logic [7:0] ev;
  always_comb begin
    ev = '0;
    ev[ISVM_ST_SERVE] = (state_ff == ISVM_WAIT_ACK) && cpu_ack_i;
    ev[ISVM_ST_TIE] = (state_ff == ISVM_IDLE) && win_tie;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      status_ff <= '0;
    end else if (clk_en_i) begin
      // set wins over write-one-to-clear
      if (reg_wr_i && reg_addr_i == ISVM_STATUS_ADDR) begin
        status_ff <= (status_ff & ~reg_wdata_i) | ev;
      end else begin
        status_ff <= status_ff | ev;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mask_ff <= ISVM_MASK_RESET;
    end else if (clk_en_i && reg_wr_i && reg_addr_i == ISVM_MASK0_ADDR) begin
      mask_ff <= reg_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      int_o <= 1'b0;
    end else if (clk_en_i) begin
      int_o <= |((status_ff | ev) & mask_ff);
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else if (clk_en_i) begin
      reg_rdata_o <= '0;
      if (reg_rd_i) begin
        if (lvl_hit) begin
          reg_rdata_o <= lvl_ff[lvl_idx[2:0]];
        end else begin
          case (reg_addr_i)
            ISVM_STATUS_ADDR: reg_rdata_o <= status_ff;
            ISVM_MASK0_ADDR: reg_rdata_o <= mask_ff;
            ISVM_PEND0_ADDR: reg_rdata_o <= req[7:0];
            ISVM_PEND1_ADDR: reg_rdata_o <= req[15:8];
            ISVM_PEND2_ADDR: reg_rdata_o <= req[23:16];
            default: reg_rdata_o <= '0;
          endcase
        end
      end
    end
  end
endmodule

/* File: isvm_pkg.sv */
package isvm_pkg;
  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int unsigned ISVM_LINES = 24;
  localparam int unsigned ISVM_LVL_REGS = 6;
  localparam int unsigned ISVM_LINE_W = 5;

  // ---------------------------------------------------------------
  // register map (level-setting, status, mask and pending registers)
  // ---------------------------------------------------------------
  localparam logic [7:0] ISVM_LVL_BASE = 8'h79;
  localparam logic [7:0] ISVM_STATUS_ADDR = 8'h70;
  localparam logic [7:0] ISVM_MASK0_ADDR = 8'h71;
  localparam logic [7:0] ISVM_MASK1_ADDR = 8'h72;
  localparam logic [7:0] ISVM_MASK2_ADDR = 8'h73;
  localparam logic [7:0] ISVM_PEND0_ADDR = 8'h74;
  localparam logic [7:0] ISVM_PEND1_ADDR = 8'h75;
  localparam logic [7:0] ISVM_PEND2_ADDR = 8'h76;
  localparam logic [7:0] ISVM_LVL_RESET = 8'hff;
  localparam logic [7:0] ISVM_MASK_RESET = 8'h00;
  localparam logic [1:0] ISVM_LVL_LOWEST = 2'h3;

  // ---------------------------------------------------------------
  // vector table
  // ---------------------------------------------------------------
  localparam logic [15:0] ISVM_VEC_TOP = 16'hfffa;

  // ---------------------------------------------------------------
  // request line numbers
  // ---------------------------------------------------------------
  localparam int unsigned ISVM_L_EXT4 = 0;
  localparam int unsigned ISVM_L_EXT5 = 1;
  localparam int unsigned ISVM_L_EXT26 = 2;
  localparam int unsigned ISVM_L_EXT37 = 3;
  localparam int unsigned ISVM_L_T0LO = 5;
  localparam int unsigned ISVM_L_T0HI = 6;
  localparam int unsigned ISVM_L_SRX = 7;
  localparam int unsigned ISVM_L_STX = 8;
  localparam int unsigned ISVM_L_T1HI = 14;
  localparam int unsigned ISVM_L_ADC = 18;
  localparam int unsigned ISVM_L_TBT = 19;
  localparam int unsigned ISVM_L_WPS = 20;
  localparam int unsigned ISVM_L_T1LO = 22;
  localparam int unsigned ISVM_L_FLASH = 23;

  // status register bits (own events)
  localparam int unsigned ISVM_ST_SERVE = 0;
  localparam int unsigned ISVM_ST_TIE = 1;

  typedef enum logic [1:0] {
    ISVM_IDLE,
    ISVM_WAIT_ACK
  } isvm_state_t;

  // upper vector address of line n is top minus 2n
  function automatic logic [15:0] isvm_vec_upper(
      input logic [ISVM_LINE_W-1:0] n);
    isvm_vec_upper = ISVM_VEC_TOP - {10'h000, n, 1'b0};
  endfunction
endpackage

/* File: isvm_monitor.sv */
module isvm_monitor (
  // clock, reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  // requests
  input wire logic [7:0] ext_irq_i,
  input wire logic adc_i,
  input wire logic timer1_lo_i,
  input wire logic cpu_ack_i,
  // offer
  input wire logic irq_req_o,
  input wire logic [4:0] irq_line_o,
  input wire logic [15:0] vec_upper_o,
  input wire logic [15:0] vec_lower_o,
  input wire logic [23:0] pend_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  property p_vu;
    irq_req_o |-> vec_upper_o == 16'hfffa - {10'h000, irq_line_o, 1'b0};
  endproperty
  a_vu: assert property (p_vu) else $error("vector upper");
  property p_vl;
    irq_req_o |-> vec_lower_o == vec_upper_o + 16'h0001;
  endproperty
  a_vl: assert property (p_vl) else $error("vector lower");
  property p_hold;
    irq_req_o && !cpu_ack_i && clk_en_i |=> irq_req_o && $stable(irq_line_o);
  endproperty
  a_hold: assert property (p_hold) else $error("offer moved");
  property p_ack;
    irq_req_o && cpu_ack_i && clk_en_i |=> !irq_req_o;
  endproperty
  a_ack: assert property (p_ack) else $error("offer kept");
  property p_ext4;
    clk_en_i && ext_irq_i[4] |=> pend_o[0];
  endproperty
  a_ext4: assert property (p_ext4) else $error("line 0");
  property p_ext26;
    clk_en_i |=> pend_o[2] == ($past(ext_irq_i[2]) | $past(ext_irq_i[6]));
  endproperty
  a_ext26: assert property (p_ext26) else $error("line 2");
  property p_adc;
    clk_en_i && adc_i |=> pend_o[18];
  endproperty
  a_adc: assert property (p_adc) else $error("line 18");
  property p_t1lo;
    clk_en_i && timer1_lo_i |=> pend_o[22];
  endproperty
  a_t1lo: assert property (p_t1lo) else $error("line 22");
  property p_idle;
    (pend_o & 24'h23be10) == 24'h000000;
  endproperty
  a_idle: assert property (p_idle) else $error("unused line");
endmodule

bind isvm_core isvm_monitor u_isvm_monitor (.core_clk_i, .rst_i, .clk_en_i,
  .ext_irq_i, .adc_i, .timer1_lo_i, .cpu_ack_i, .irq_req_o, .irq_line_o,
  .vec_upper_o, .vec_lower_o, .pend_o);

/* File: isvm_cpu_model.sv */
module isvm_cpu_model (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic irq_req_i,
  input wire logic [1:0] wait_i,
  output logic ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_ff;
  logic ack_ff;
  assign ack_o = ack_ff;
  // one ack pulse per offer, after wait_i + 1 idle cycles
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !irq_req_i || ack_ff) begin
      cnt_ff <= 2'h0;
      ack_ff <= 1'b0;
    end else if (cnt_ff == wait_i) begin
      ack_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 2'h1;
    end
  end
endmodule

/* File: tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic clk_en_i = 1'b1;
  logic [15:0] src = 16'h0000;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [1:0] ack_wait = 2'h0;
  logic cpu_ack, irq_req, int_sig;
  logic [4:0] irq_line;
  logic [1:0] irq_level;
  logic [15:0] vec_up, vec_lo;
  logic [23:0] pend;
  logic [7:0] rdata;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int lines [16] = '{0, 1, 2, 2, 3, 3, 5, 6, 7, 8, 14, 18, 19, 20, 22, 23};

  isvm_core u_isvm_core (.core_clk_i, .rst_i, .clk_en_i,
    .ext_irq_i({src[5], src[3], src[1], src[0], src[4], src[2], 2'h0}),
    .timer0_lo_i(src[6]), .timer0_hi_i(src[7]), .serial_rx_i(src[8]),
    .serial_tx_i(src[9]), .timer1_hi_i(src[10]), .adc_i(src[11]),
    .timebase_i(src[12]), .watch_i(src[13]), .timer1_lo_i(src[14]),
    .flash_i(src[15]), .cpu_ack_i(cpu_ack), .irq_req_o(irq_req),
    .irq_line_o(irq_line), .irq_level_o(irq_level), .vec_upper_o(vec_up),
    .vec_lower_o(vec_lo), .pend_o(pend), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(rdata), .int_o(int_sig));
  isvm_cpu_model u_isvm_cpu_model (.core_clk_i, .rst_i,
    .irq_req_i(irq_req), .wait_i(ack_wait), .ack_o(cpu_ack));

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk_i);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk_i);
    reg_rd <= 1'b0;
    @(posedge core_clk_i);
    chk({16'h0000, rdata}, {16'h0000, exp});
  endtask
  task automatic wait_req(input logic lvl);
    int k;
    k = 0;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (irq_req !== lvl && k < 20);
    chk({23'h0, irq_req}, {23'h0, lvl});
  endtask
  // raise sources, expect line n with its vector pair, then let cpu take it
  task automatic offer(input logic [15:0] s, input int n,
      input logic [1:0] l);
    src <= s;
    wait_req(1'b1);
    src <= 16'h0000;
    chk({19'h0, irq_line}, 24'(n));
    chk({22'h0, irq_level}, {22'h0, l});
    chk({8'h00, vec_up}, {8'h00, 16'hfffa - 16'(2 * n)});
    chk({8'h00, vec_lo}, {8'h00, 16'hfffb - 16'(2 * n)});
    wait_req(1'b0);
  endtask

  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) rd(8'h79 + 8'(i), 8'hff);
    rd(8'h7f, 8'h00);
    wr(8'h79, 8'h5a);
    rd(8'h79, 8'h5a);
    // read data stands one cycle only
    @(posedge core_clk_i);
    chk({16'h0000, rdata}, 24'h000000);
    // writes are ignored while the clock enable is low
    clk_en_i <= 1'b0;
    wr(8'h79, 8'h00);
    clk_en_i <= 1'b1;
    rd(8'h79, 8'h5a);
    wr(8'h79, 8'hff);
    for (int i = 0; i < 6; i++) begin
      ack_wait <= 2'(i % 3);
      offer(16'(1 << i), lines[i], 2'h3);
    end
    for (int i = 6; i < 16; i++) begin
      ack_wait <= 2'(i % 3);
      offer(16'(1 << i), lines[i], 2'h3);
    end
    offer(16'hc800, 18, 2'h3);
    wr(8'h7e, 8'h3f);
    rd(8'h7e, 8'h3f);
    offer(16'hc800, 23, 2'h0);
    // live request lines through the pending registers
    src <= 16'h8101;
    rd(8'h74, 8'h81);
    rd(8'h75, 8'h00);
    rd(8'h76, 8'h80);
    src <= 16'h0000;
    wait_req(1'b0);
    wr(8'h71, 8'h01);
    repeat (2) @(posedge core_clk_i);
    chk({23'h0, int_sig}, 24'h000001);
    wr(8'h70, 8'h03);
    repeat (2) @(posedge core_clk_i);
    chk({23'h0, int_sig}, 24'h000000);
    rd(8'h70, 8'h00);
    // second reset in mid-run restores the level registers
    rst_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(8'h7e, 8'hff);
    chk({8'h00, vec_up}, 24'h00fffa);
    give_verdict();
  end
endmodule
